// ### sbl_pkg.sv
package sbl_pkg;

  // Timing of the internal reset sequence
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_SEQ_MIN_US = 15;
  localparam int RST_SEQ_CYC = (RST_SEQ_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

  // Security configuration register layout
  localparam int SEC_DEBUG_PORT_BLOCK = 0;
  localparam int SEC_LINK_ACCESS_BLOCK = 1;
  localparam int SEC_OTP_BOOT_SELECT = 5;
  localparam int SEC_SPARE_ROW_ENABLE = 7;
  localparam int SEC_SECTOR_LOCK_LO = 8;
  localparam int SEC_PROGRAM_LOCK_ALL = 12;
  localparam int SEC_DEBUG_OTP_BLOCK = 13;
  localparam int SEC_USER_LO = 15;
  localparam int SEC_USER_HI = 21;
  localparam int SEC_UID_LO = 22;
  localparam int SEC_UID_HI = 31;
  localparam int OTP_SECTORS = 4;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [31:0] SEC_USER_MASK = 32'h003F_8000;

  // Image format and check
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_BYPASS = 32'h0D15_AB1E;
  localparam logic [1:0] WORD_LAST_BYTE = 2'h3;

  // Tile RAM
  localparam int RAM_ADDR_W = 18;
  localparam logic [RAM_ADDR_W-1:0] RAM_BASE = 18'h0_0000;

  typedef enum logic [2:0] {
    SBL_ST_RESET,
    SBL_ST_SIZE,
    SBL_ST_PROG,
    SBL_ST_CRC,
    SBL_ST_CHECK,
    SBL_ST_RUN,
    SBL_ST_HALT
  } sbl_state_e;

endpackage : sbl_pkg

// ### sbl_crc32.sv
`timescale 1ns/100ps
module sbl_crc32
  import sbl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  output logic [31:0] crc_o
);

  // Reflected CRC, one byte per enable, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= CRC_INIT;
    end else if (init_i) begin
      crc_o <= CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_byte(crc_o, data_i);
    end
  end

endmodule : sbl_crc32

// ### sbl_loader.sv
`timescale 1ns/100ps
// Summary of operation
// - While reset pin is low, hold the loader in reset and pull I/O down.
// - After reset release, wait the internal sequence, then begin booting.
// - Security bit 5 selects boot from OTP address 0, else internal flash.
// - Image is size word, then size times four bytes, then check word.
// - Size and check words arrive least significant byte first.
// - A check word of the bypass marker skips CRC verification.
// - CRC covers the size word bytes and all program bytes.
// - CRC uses the reflected polynomial 0xEDB88320.
// - Program bytes load from the lowest RAM address; execution starts there.
// - Security bit 0 refuses debug port access to tile state and memory.
// - Security bit 1 denies other tiles access through the system switch.
// - Security bit 7 enables the redundant OTP rows.
// - Security bits 8 to 11 block programming of OTP sectors 0 to 3.
// - Security bit 12 rejects all OTP programming and all security register writes except the user field.
// - Security bit 13 denies debug port reads and writes of the OTP.
// - Bits 21 to 15 form a software accessible user field.
// - Bits 31 to 22 extend the debug port user identification code.
module sbl_loader
  import sbl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic rst_pin_n_i,
  output logic gpio_pulldown_o,
  // Boot image link, on its own clock
  input wire logic link_clk_i,
  input wire logic link_valid_i,
  input wire logic [7:0] link_byte_i,
  output logic link_ready_o,
  output logic fetch_en_o,
  output logic boot_from_otp_o,
  // Tile RAM write port
  output logic ram_we_o,
  output logic [RAM_ADDR_W-1:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  // Execution control
  output logic exec_start_o,
  output logic [RAM_ADDR_W-1:0] exec_addr_o,
  output logic boot_fail_o,
  // Security configuration register
  input wire logic sec_wr_i,
  input wire logic [31:0] sec_wdata_i,
  output logic [31:0] sec_rdata_o,
  output logic otp_spare_rows_o,
  output logic [SEC_UID_HI-SEC_UID_LO:0] debug_userid_ext_o,
  // Access requests checked against the security bits
  input wire logic dbg_tile_req_i,
  output logic dbg_tile_deny_o,
  input wire logic switch_req_i,
  output logic switch_deny_o,
  input wire logic dbg_otp_req_i,
  output logic dbg_otp_deny_o,
  input wire logic otp_prog_req_i,
  input wire logic [1:0] otp_prog_sector_i,
  output logic otp_prog_grant_o,
  output logic otp_prog_deny_o
);

  function automatic logic sector_locked(input logic [31:0] sec, input logic [1:0] sector);
    return sec[SEC_PROGRAM_LOCK_ALL] | sec[SEC_SECTOR_LOCK_LO + int'(sector)];
  endfunction : sector_locked

  logic [7:0] link_hold_r;
  logic link_req_tgl_r;
  logic link_ack_s1_r;
  logic link_ack_s2_r;
  logic link_ack_seen_r;
  logic sys_ack_tgl_r;

  // Byte capture; ready drops until the system side acknowledges
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_hold_r <= 8'h00;
      link_req_tgl_r <= 1'b0;
    end else if (link_valid_i && link_ready_o) begin
      link_hold_r <= link_byte_i;
      link_req_tgl_r <= ~link_req_tgl_r;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_ack_s1_r <= 1'b0;
      link_ack_s2_r <= 1'b0;
    end else begin
      link_ack_s1_r <= sys_ack_tgl_r;
      link_ack_s2_r <= link_ack_s1_r;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_ack_seen_r <= 1'b0;
      link_ready_o <= 1'b1;
    end else if (link_valid_i && link_ready_o) begin
      link_ready_o <= 1'b0;
    end else if (link_ack_s2_r != link_ack_seen_r) begin
      link_ack_seen_r <= link_ack_s2_r;
      link_ready_o <= 1'b1;
    end
  end

  logic pin_s1_r;
  logic pin_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic req_seen_r;
  logic byte_vld;
  logic [7:0] byte_in;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= rst_pin_n_i;
      pin_s2_r <= pin_s1_r;
      req_s1_r <= link_req_tgl_r;
      req_s2_r <= req_s1_r;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_pulldown_o <= 1'b1;
    end else begin
      gpio_pulldown_o <= ~pin_s2_r;
    end
  end

  // Hold register is stable while the toggle is unacknowledged
  assign byte_vld = (req_s2_r != req_seen_r);
  assign byte_in = link_hold_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_seen_r <= 1'b0;
      sys_ack_tgl_r <= 1'b0;
    end else if (byte_vld) begin
      req_seen_r <= req_s2_r;
      sys_ack_tgl_r <= ~sys_ack_tgl_r;
    end
  end

  logic [31:0] sec_r;
  logic [31:0] sec_nxt;

  always_comb begin
    sec_nxt = sec_r;
    if (sec_wr_i && sec_r[SEC_PROGRAM_LOCK_ALL]) begin
      sec_nxt = (sec_r & ~SEC_USER_MASK) | (sec_wdata_i & SEC_USER_MASK);
    end else if (sec_wr_i) begin
      sec_nxt = sec_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sec_r <= SEC_RESET;
    end else begin
      sec_r <= sec_nxt;
    end
  end

  assign sec_rdata_o = sec_r;
  assign otp_spare_rows_o = sec_r[SEC_SPARE_ROW_ENABLE];
  assign debug_userid_ext_o = sec_r[SEC_UID_HI:SEC_UID_LO];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_tile_deny_o <= 1'b0;
      switch_deny_o <= 1'b0;
      dbg_otp_deny_o <= 1'b0;
    end else begin
      dbg_tile_deny_o <= dbg_tile_req_i & sec_r[SEC_DEBUG_PORT_BLOCK];
      switch_deny_o <= switch_req_i & sec_r[SEC_LINK_ACCESS_BLOCK];
      dbg_otp_deny_o <= dbg_otp_req_i & sec_r[SEC_DEBUG_OTP_BLOCK];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      otp_prog_grant_o <= 1'b0;
      otp_prog_deny_o <= 1'b0;
    end else begin
      otp_prog_grant_o <= otp_prog_req_i & ~sector_locked(sec_r, otp_prog_sector_i);
      otp_prog_deny_o <= otp_prog_req_i & sector_locked(sec_r, otp_prog_sector_i);
    end
  end

  sbl_state_e state_r;
  logic [RST_CNT_W-1:0] dly_r;
  logic [1:0] bcnt_r;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic [33:0] remain_r;
  logic crc_init;
  logic crc_en;
  logic [31:0] crc_val;

  assign word_nxt = {byte_in, word_r[31:8]};
  assign crc_init = (state_r == SBL_ST_RESET);
  assign crc_en = byte_vld && ((state_r == SBL_ST_SIZE) || (state_r == SBL_ST_PROG));

  sbl_crc32 u_crc (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .en_i(crc_en),
    .data_i(byte_in),
    .crc_o(crc_val)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dly_r <= '0;
    end else if (!pin_s2_r || state_r != SBL_ST_RESET) begin
      dly_r <= '0;
    end else begin
      dly_r <= dly_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SBL_ST_RESET;
    end else if (!pin_s2_r) begin
      state_r <= SBL_ST_RESET;
    end else begin
      unique case (state_r)
        SBL_ST_RESET: begin
          if (dly_r == RST_CNT_W'(RST_SEQ_CYC - 1)) begin
            state_r <= SBL_ST_SIZE;
          end
        end
        SBL_ST_SIZE: begin
          if (byte_vld && bcnt_r == WORD_LAST_BYTE) begin
            state_r <= (word_nxt == 32'h0000_0000) ? SBL_ST_CRC : SBL_ST_PROG;
          end
        end
        SBL_ST_PROG: begin
          if (byte_vld && remain_r == 34'h1) begin
            state_r <= SBL_ST_CRC;
          end
        end
        SBL_ST_CRC: begin
          if (byte_vld && bcnt_r == WORD_LAST_BYTE) begin
            state_r <= SBL_ST_CHECK;
          end
        end
        SBL_ST_CHECK: begin
          if (word_r == CRC_BYPASS || ~crc_val == word_r) begin
            state_r <= SBL_ST_RUN;
          end else begin
            state_r <= SBL_ST_HALT;
          end
        end
        SBL_ST_RUN, SBL_ST_HALT: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Byte position within size and check words
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt_r <= 2'h0;
      word_r <= 32'h0000_0000;
    end else if (state_r == SBL_ST_RESET) begin
      bcnt_r <= 2'h0;
      word_r <= 32'h0000_0000;
    end else if (byte_vld && (state_r == SBL_ST_SIZE || state_r == SBL_ST_CRC)) begin
      bcnt_r <= bcnt_r + 2'h1;
      word_r <= word_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      remain_r <= 34'h0;
    end else if (byte_vld && state_r == SBL_ST_SIZE && bcnt_r == WORD_LAST_BYTE) begin
      remain_r <= {word_nxt, 2'b00};
    end else if (byte_vld && state_r == SBL_ST_PROG) begin
      remain_r <= remain_r - 34'h1;
    end
  end

  // RAM writes start at the lowest address
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ram_we_o <= 1'b0;
      ram_addr_o <= RAM_BASE;
      ram_wdata_o <= 8'h00;
    end else begin
      ram_we_o <= byte_vld && state_r == SBL_ST_PROG && pin_s2_r;
      if (state_r == SBL_ST_RESET) begin
        ram_addr_o <= RAM_BASE;
      end else if (ram_we_o) begin
        ram_addr_o <= ram_addr_o + 1'b1;
      end
      if (byte_vld) begin
        ram_wdata_o <= byte_in;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_en_o <= 1'b0;
      boot_from_otp_o <= 1'b0;
    end else if (!pin_s2_r || state_r == SBL_ST_CHECK) begin
      fetch_en_o <= 1'b0;
    end else if (state_r == SBL_ST_RESET && dly_r == RST_CNT_W'(RST_SEQ_CYC - 1)) begin
      fetch_en_o <= 1'b1;
      boot_from_otp_o <= sec_r[SEC_OTP_BOOT_SELECT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      exec_start_o <= 1'b0;
      exec_addr_o <= RAM_BASE;
      boot_fail_o <= 1'b0;
    end else begin
      exec_start_o <= pin_s2_r && (state_r == SBL_ST_RUN);
      exec_addr_o <= RAM_BASE;
      boot_fail_o <= pin_s2_r && (state_r == SBL_ST_HALT);
    end
  end

endmodule : sbl_loader

// ### sbl_loader_sva.sv
`timescale 1ns/100ps
module sbl_loader_sva
  import sbl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic rst_pin_n_i,
  input wire logic gpio_pulldown_o,
  input wire logic link_clk_i,
  input wire logic link_valid_i,
  input wire logic link_ready_o,
  input wire logic fetch_en_o,
  input wire logic exec_start_o,
  input wire logic [RAM_ADDR_W-1:0] exec_addr_o,
  input wire logic boot_fail_o,
  input wire logic sec_wr_i,
  input wire logic [31:0] sec_wdata_i,
  input wire logic [31:0] sec_rdata_o,
  input wire logic dbg_tile_req_i,
  input wire logic dbg_tile_deny_o,
  input wire logic switch_req_i,
  input wire logic switch_deny_o,
  input wire logic dbg_otp_req_i,
  input wire logic dbg_otp_deny_o,
  input wire logic otp_prog_req_i,
  input wire logic [1:0] otp_prog_sector_i,
  input wire logic otp_prog_grant_o,
  input wire logic otp_prog_deny_o
);
  AST_PULLDOWN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !rst_pin_n_i [*4] |-> gpio_pulldown_o) else $error("pull-down off in reset");
  AST_BOOT_DELAY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(rst_pin_n_i) |-> (!fetch_en_o throughout (##149 1'b1)) ##[1:10] fetch_en_o)
    else $error("boot start out of window");
  AST_LINK_TAKE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    link_valid_i && link_ready_o |=> !link_ready_o) else $error("ready held after take");
  AST_TILE_DENY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    dbg_tile_req_i |=> dbg_tile_deny_o == $past(sec_rdata_o[SEC_DEBUG_PORT_BLOCK]))
    else $error("tile deny wrong");
  AST_SWITCH_DENY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    switch_req_i |=> switch_deny_o == $past(sec_rdata_o[SEC_LINK_ACCESS_BLOCK]))
    else $error("switch deny wrong");
  AST_OTP_DENY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    dbg_otp_req_i |=> dbg_otp_deny_o == $past(sec_rdata_o[SEC_DEBUG_OTP_BLOCK]))
    else $error("otp debug deny wrong");
  AST_PROG_DENY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    otp_prog_req_i && (sec_rdata_o[SEC_PROGRAM_LOCK_ALL]
    || sec_rdata_o[SEC_SECTOR_LOCK_LO + otp_prog_sector_i])
    |=> otp_prog_deny_o && !otp_prog_grant_o) else $error("locked sector granted");
  AST_PROG_GRANT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    otp_prog_req_i && !sec_rdata_o[SEC_PROGRAM_LOCK_ALL]
    && !sec_rdata_o[SEC_SECTOR_LOCK_LO + otp_prog_sector_i]
    |=> otp_prog_grant_o && !otp_prog_deny_o) else $error("open sector denied");
  AST_SEC_LOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sec_wr_i && sec_rdata_o[SEC_PROGRAM_LOCK_ALL] |=>
    (sec_rdata_o & ~SEC_USER_MASK) == ($past(sec_rdata_o) & ~SEC_USER_MASK))
    else $error("locked bits changed");
  AST_SEC_USER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sec_wr_i |=> (sec_rdata_o & SEC_USER_MASK) == ($past(sec_wdata_i) & SEC_USER_MASK))
    else $error("user field not written");
  AST_EXEC_ADDR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(exec_start_o) |-> exec_addr_o == RAM_BASE && !boot_fail_o)
    else $error("bad start address");
  AST_FAIL_HALT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(boot_fail_o) |-> !exec_start_o [*8]) else $error("program ran after fail");
endmodule : sbl_loader_sva

bind sbl_loader sbl_loader_sva u_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
  .gpio_pulldown_o(gpio_pulldown_o), .link_clk_i(link_clk_i), .link_valid_i(link_valid_i),
  .link_ready_o(link_ready_o), .fetch_en_o(fetch_en_o), .exec_start_o(exec_start_o),
  .exec_addr_o(exec_addr_o), .boot_fail_o(boot_fail_o), .sec_wr_i(sec_wr_i),
  .sec_wdata_i(sec_wdata_i), .sec_rdata_o(sec_rdata_o), .dbg_tile_req_i(dbg_tile_req_i),
  .dbg_tile_deny_o(dbg_tile_deny_o), .switch_req_i(switch_req_i),
  .switch_deny_o(switch_deny_o), .dbg_otp_req_i(dbg_otp_req_i),
  .dbg_otp_deny_o(dbg_otp_deny_o), .otp_prog_req_i(otp_prog_req_i),
  .otp_prog_sector_i(otp_prog_sector_i), .otp_prog_grant_o(otp_prog_grant_o),
  .otp_prog_deny_o(otp_prog_deny_o)
);

// ### sbl_image_src.sv
`timescale 1ns/100ps
module sbl_image_src (
  output logic link_clk_o,
  output logic link_valid_o,
  output logic [7:0] link_byte_o,
  input wire logic link_ready_i
);
  byte unsigned q[$];
  logic rdy;
  // Ready is taken just ahead of the rising edge
  task automatic tick();
    #23 link_clk_o = 1'b0;
    #23 rdy = link_ready_i;
    #1 link_clk_o = 1'b1;
    #1;
  endtask : tick
  // Clock runs while an image is pending and for 8 ticks after; valid drops for 0 to 2 ticks ahead of each byte
  initial begin
    link_clk_o = 1'b1;
    link_valid_o = 1'b0;
    link_byte_o = 8'h00;
    forever begin
      while (q.size() == 0) #10;
      while (q.size() != 0) begin
        repeat ($urandom_range(0, 2)) begin
          link_valid_o = 1'b0;
          link_byte_o = ~link_byte_o;
          tick();
        end
        link_valid_o = 1'b1;
        link_byte_o = q.pop_front();
        do tick(); while (rdy !== 1'b1);
      end
      link_valid_o = 1'b0;
      link_byte_o = ~link_byte_o;
      repeat (8) tick();
    end
  end
endmodule : sbl_image_src

// ### test_secure_boot_image_loader.sv
`timescale 1ns/100ps
module test_secure_boot_image_loader;
  import sbl_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, rst_pin_n_i = 0, link_clk_i, link_valid_i;
  logic [7:0] link_byte_i, ram_wdata_o;
  logic sec_wr_i = 0, dbg_tile_req_i = 0, switch_req_i = 0, dbg_otp_req_i = 0;
  logic otp_prog_req_i = 0, gpio_pulldown_o, link_ready_o, fetch_en_o, boot_from_otp_o;
  logic [1:0] otp_prog_sector_i = 0;
  logic [31:0] sec_wdata_i = 0, sec_rdata_o, v;
  logic ram_we_o, exec_start_o, boot_fail_o, otp_spare_rows_o;
  logic [RAM_ADDR_W-1:0] ram_addr_o, exec_addr_o;
  logic [9:0] debug_userid_ext_o;
  logic dbg_tile_deny_o, switch_deny_o, dbg_otp_deny_o, otp_prog_grant_o, otp_prog_deny_o;
  int bad_count = 0, n_compared = 0;
  byte unsigned img[$];
  logic [7:0] ram[$];
  always #50 clk_sys_i = ~clk_sys_i;
  sbl_loader u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
    .gpio_pulldown_o(gpio_pulldown_o), .link_clk_i(link_clk_i), .link_valid_i(link_valid_i),
    .link_byte_i(link_byte_i), .link_ready_o(link_ready_o), .fetch_en_o(fetch_en_o),
    .boot_from_otp_o(boot_from_otp_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .exec_start_o(exec_start_o), .exec_addr_o(exec_addr_o),
    .boot_fail_o(boot_fail_o), .sec_wr_i(sec_wr_i), .sec_wdata_i(sec_wdata_i),
    .sec_rdata_o(sec_rdata_o), .otp_spare_rows_o(otp_spare_rows_o),
    .debug_userid_ext_o(debug_userid_ext_o), .dbg_tile_req_i(dbg_tile_req_i),
    .dbg_tile_deny_o(dbg_tile_deny_o), .switch_req_i(switch_req_i),
    .switch_deny_o(switch_deny_o), .dbg_otp_req_i(dbg_otp_req_i),
    .dbg_otp_deny_o(dbg_otp_deny_o), .otp_prog_req_i(otp_prog_req_i),
    .otp_prog_sector_i(otp_prog_sector_i), .otp_prog_grant_o(otp_prog_grant_o),
    .otp_prog_deny_o(otp_prog_deny_o)
  );
  sbl_image_src u_src (.link_clk_o(link_clk_i), .link_valid_o(link_valid_i),
    .link_byte_o(link_byte_i), .link_ready_i(link_ready_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask : chkb
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_sys_i) if (ram_we_o === 1'b1) begin
    chk(32'(ram_addr_o), 32'(ram.size()));
    ram.push_back(ram_wdata_o);
  end
  function automatic logic [31:0] crc32(byte unsigned b[$]);
    logic [31:0] c = '1;
    foreach (b[i]) begin
      c ^= 32'(b[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction : crc32
  task automatic put32(input logic [31:0] w);
    for (int i = 0; i < 4; i++) img.push_back(w[8*i +: 8]);
  endtask : put32
  // Mode 0 good check word, 1 bypass marker, 2 corrupt check word
  task automatic boot(input int s, input int mode, input logic otp);
    int n;
    rst_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chkb(gpio_pulldown_o, 1'b1);
    rst_pin_n_i <= 1'b1;
    for (n = 0; fetch_en_o !== 1'b1 && n < 2000; n++) @(posedge clk_sys_i);
    chkb(n >= 150 && n <= 1500, 1'b1);
    chkb(boot_from_otp_o, otp);
    img = {};
    ram = {};
    put32(32'(s));
    repeat (4 * s) img.push_back(8'($urandom));
    v = crc32(img);
    put32(mode == 1 ? 32'h0D15_AB1E : mode == 2 ? ~v : v);
    u_src.q = img;
    for (n = 0; !exec_start_o && !boot_fail_o && n < 5000; n++) @(posedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    chkb(exec_start_o, mode != 2);
    chkb(boot_fail_o, mode == 2);
    chk(32'(exec_addr_o), 0);
    chk(32'(ram.size()), 32'(4 * s));
    foreach (ram[i]) chk(32'(ram[i]), 32'(img[i + 4]));
  endtask : boot
  task automatic sec_write(input logic [31:0] d);
    sec_wr_i <= 1'b1;
    sec_wdata_i <= d;
    @(posedge clk_sys_i);
    sec_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : sec_write
  task automatic access(input logic [31:0] d);
    sec_write(d);
    chk(sec_rdata_o, d);
    chkb(otp_spare_rows_o, d[7]);
    chk(32'(debug_userid_ext_o), 32'(d[31:22]));
    for (int k = 0; k < 4; k++) begin
      {dbg_tile_req_i, switch_req_i, dbg_otp_req_i, otp_prog_req_i} <= 4'hF;
      otp_prog_sector_i <= 2'(k);
      @(posedge clk_sys_i);
      {dbg_tile_req_i, switch_req_i, dbg_otp_req_i, otp_prog_req_i} <= 4'h0;
      @(posedge clk_sys_i);
      chkb(dbg_tile_deny_o, d[0]);
      chkb(switch_deny_o, d[1]);
      chkb(dbg_otp_deny_o, d[13]);
      chkb(otp_prog_deny_o, d[12] | d[8 + k]);
      chkb(otp_prog_grant_o, !(d[12] | d[8 + k]));
    end
  endtask : access
  initial begin
    #2_000_000;
    bad_count++;
    finish_test();
  end
  initial begin
    void'($urandom(6281));
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(sec_rdata_o, 0);
    boot($urandom_range(1, 8), 0, 1'b0);
    boot(0, 1, 1'b0);
    boot($urandom_range(1, 8), 1, 1'b0);
    boot($urandom_range(1, 8), 2, 1'b0);
    repeat (4) access($urandom & 32'hFFFF_EFFF);
    access(32'h0000_0020);
    boot($urandom_range(1, 8), 0, 1'b1);
    v = $urandom | 32'h0000_1000;
    access(v);
    sec_write(~v);
    chk(sec_rdata_o, (v & ~SEC_USER_MASK) | (~v & SEC_USER_MASK));
    finish_test();
  end
endmodule : test_secure_boot_image_loader
